// [hw/bac_params.svh]
// Constants for the barrier and ordering control block
// How it works
// - Sync barrier completes only after all earlier required-type accesses complete
// - Sync barrier on reads and writes also waits for earlier maintenance
// - Sync barrier waits for earlier context-altering control space accesses
// - Instructions after a sync barrier are held until it completes
// - Later accesses form group B and stay behind the barrier
// - Observers see every group A access before any group B access
// - Peripheral sees group A device or non-cacheable accesses first
// - Later instructions cannot learn values of earlier speculative loads
// - Dependent later load, store or preload cannot leak via cache allocation
// - Dependent indirect branch cannot leak via cache allocation
// - Speculation barrier completes only once known non-speculative
// - Reduced profile cores lack the speculation barrier
// - Physical store-bypass barrier stops stale or future store data
// - Store-bypass barrier stops stale or future store data
// - Reduced profile cores lack both store-bypass barriers
// - Sync barrier completion means earlier control space writes completed
// - Context sync makes completed control space write effects visible
// - Normal memory may be treated as idempotent
// - Normal non-cacheable is shareable; speculation allowed on normal memory
// - Non-cacheable normal writes finish in finite time without barriers
// - Multi-register normal accesses may use any register order
// - Group A holds all required-type accesses seen before the barrier
`ifndef BAC_PARAMS_SVH
`define BAC_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes and options
// ----------------------------------------------------------------
`define BAC_CLASS_N 4
`define BAC_CNT_W 6
`define BAC_FULL_PROFILE 1
`define BAC_WR_TIMEOUT_CYC 4096

// ----------------------------------------------------------------
// Attribute vector positions
// ----------------------------------------------------------------
`define BAC_ATTR_SHARE 3
`define BAC_ATTR_SPEC 2
`define BAC_ATTR_MERGE 1
`define BAC_ATTR_ANYORD 0

`endif

// [hw/bac_pkg.sv]
// Types shared by the barrier and ordering control block
package bac_pkg;

  // Operations offered by the issue stage
  typedef enum logic [3:0] {
    BAC_OP_NONE,
    BAC_OP_LOAD,
    BAC_OP_STORE,
    BAC_OP_PRELOAD,
    BAC_OP_MAINT,
    BAC_OP_SCS_WRITE,
    BAC_OP_IND_BRANCH,
    BAC_OP_DATA_SYNC,
    BAC_OP_SPEC_DATA,
    BAC_OP_PHYS_SB,
    BAC_OP_SB,
    BAC_OP_INSTR_SYNC
  } bac_op_t;

  // Outstanding access classes
  typedef enum logic [1:0] {
    BAC_CL_READ,
    BAC_CL_WRITE,
    BAC_CL_MAINT,
    BAC_CL_SCS
  } bac_class_t;

  // Barrier unit states
  typedef enum logic [2:0] {
    BAC_ST_IDLE,
    BAC_ST_DSB_WAIT,
    BAC_ST_SPECULATION_DATA_BARRIER_WAIT,
    BAC_ST_SSB_WAIT,
    BAC_ST_ISB_WAIT
  } bac_state_t;

endpackage : bac_pkg

// [hw/bac_track_if.sv]
// Link between barrier control and its outstanding-access tracker
`timescale 1ns/1ps
`default_nettype none
`include "bac_params.svh"
interface bac_track_if;
  logic [`BAC_CLASS_N-1:0] inc;
  logic [`BAC_CLASS_N-1:0] dec;
  logic [`BAC_CLASS_N-1:0] idle;
  logic full;

  modport ctrl (output inc, output dec, input idle, input full);
  modport trk (input inc, input dec, output idle, output full);
endinterface : bac_track_if
`default_nettype wire

// [hw/bac_outstanding.sv]
// Counters of issued but not yet completed accesses, one per class
`timescale 1ns/1ps
`default_nettype none
`include "bac_params.svh"
module bac_outstanding #(
  parameter int CNT_W = `BAC_CNT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Tracker side of the link
  bac_track_if.trk trk
);

  logic [CNT_W-1:0] cnt [`BAC_CLASS_N];
  logic [CNT_W-1:0] next_cnt [`BAC_CLASS_N];

  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
    $error("bac_outstanding: CNT_W out of range");
  end

  // ----------------------------------------------------------------
  // Next counts
  // ----------------------------------------------------------------
  always_comb begin
    trk.full = 1'b0;
    for (int i = 0; i < `BAC_CLASS_N; i++) begin
      next_cnt[i] = cnt[i];
      if (trk.inc[i] && !trk.dec[i]) begin
        next_cnt[i] = cnt[i] + CNT_W'(1);
      end else if (!trk.inc[i] && trk.dec[i] && cnt[i] != '0) begin
        next_cnt[i] = cnt[i] - CNT_W'(1);
      end
      trk.idle[i] = (cnt[i] == '0);
      if (cnt[i] == {CNT_W{1'b1}}) begin
        trk.full = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `BAC_CLASS_N; i++) begin
      if (rst) begin
        cnt[i] <= '0;
      end else if (ce) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

endmodule : bac_outstanding
`default_nettype wire

// [hw/bac_barrier_ctrl.sv]
// Barrier and speculation ordering control between issue and memory
`timescale 1ns/1ps
`default_nettype none
`include "bac_params.svh"
module bac_barrier_ctrl #(
  parameter int CNT_W = `BAC_CNT_W,
  parameter bit FULL_PROFILE = `BAC_FULL_PROFILE,
  parameter int WR_TIMEOUT_CYC = `BAC_WR_TIMEOUT_CYC
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Issue stage request
  input wire logic iss_valid,
  input wire bac_pkg::bac_op_t iss_op,
  input wire logic iss_dsb_reads,
  input wire logic iss_dsb_writes,
  input wire logic iss_speculative,
  input wire logic iss_cmov_dep,
  input wire logic iss_normal,
  input wire logic iss_cacheable,
  input wire logic iss_shareable,
  // Issue stage answer
  output logic iss_stall,
  output logic barrier_done,
  output logic undef_op,
  // Speculation tracking
  input wire logic spec_resolved,
  input wire logic spec_flush,
  input wire logic older_spec_loads,
  output logic alloc_inhibit,
  // Store buffer state
  input wire logic st_addr_unknown,
  input wire logic st_phys_unknown,
  output logic bypass_inhibit,
  // Context synchronization
  input wire logic ctx_sync_evt,
  output logic scs_visible,
  // Memory request and completion
  output logic mem_req_valid,
  output bac_pkg::bac_class_t mem_req_class,
  output logic [3:0] mem_req_attr,
  input wire logic mem_rd_done,
  input wire logic mem_wr_done,
  input wire logic mem_maint_done,
  input wire logic mem_scs_done,
  output logic wr_stuck
);

  if (WR_TIMEOUT_CYC < 2 || WR_TIMEOUT_CYC > 65535) begin : g_bad_timeout
    $error("bac_barrier_ctrl: WR_TIMEOUT_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Attribute decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] attr_of(input logic normal,
                                         input logic cacheable,
                                         input logic shareable);
    logic [3:0] a;
    a = 4'h0;
    // Device and normal non-cacheable are always shareable
    a[`BAC_ATTR_SHARE] = shareable | ~normal | ~cacheable;
    a[`BAC_ATTR_SPEC] = normal;
    a[`BAC_ATTR_MERGE] = normal;
    a[`BAC_ATTR_ANYORD] = normal;
    return a;
  endfunction : attr_of

  function automatic logic is_access(input bac_pkg::bac_op_t op);
    return op == bac_pkg::BAC_OP_LOAD || op == bac_pkg::BAC_OP_STORE ||
           op == bac_pkg::BAC_OP_PRELOAD || op == bac_pkg::BAC_OP_MAINT ||
           op == bac_pkg::BAC_OP_SCS_WRITE;
  endfunction : is_access

  function automatic bac_pkg::bac_class_t class_of(
      input bac_pkg::bac_op_t op);
    case (op)
      bac_pkg::BAC_OP_STORE: return bac_pkg::BAC_CL_WRITE;
      bac_pkg::BAC_OP_MAINT: return bac_pkg::BAC_CL_MAINT;
      bac_pkg::BAC_OP_SCS_WRITE: return bac_pkg::BAC_CL_SCS;
      default: return bac_pkg::BAC_CL_READ;
    endcase
  endfunction : class_of

  // ----------------------------------------------------------------
  // Tracker
  // ----------------------------------------------------------------
  bac_track_if trk_if ();

  bac_outstanding #(
    .CNT_W(CNT_W)
  ) u_outstanding (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .trk(trk_if.trk)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bac_pkg::bac_state_t state;
  bac_pkg::bac_state_t next_state;
  logic need_rd;
  logic next_need_rd;
  logic need_wr;
  logic next_need_wr;
  logic need_maint;
  logic next_need_maint;
  logic spec_pend;
  logic next_spec_pend;
  logic phys_sb;
  logic next_phys_sb;
  logic next_barrier_done;
  logic next_undef_op;
  logic next_scs_visible;
  logic next_mem_req_valid;
  bac_pkg::bac_class_t next_mem_req_class;
  logic [3:0] next_mem_req_attr;
  logic [15:0] wr_age;
  logic [15:0] next_wr_age;
  logic next_wr_stuck;

  logic accept;
  logic dep_op;
  logic dsb_met;
  logic ssb_met;
  logic rd_idle;
  logic wr_idle;
  logic maint_idle;
  logic scs_idle;

  assign rd_idle = trk_if.idle[bac_pkg::BAC_CL_READ];
  assign wr_idle = trk_if.idle[bac_pkg::BAC_CL_WRITE];
  assign maint_idle = trk_if.idle[bac_pkg::BAC_CL_MAINT];
  assign scs_idle = trk_if.idle[bac_pkg::BAC_CL_SCS];

  // Ops that could expose speculative data through cache allocation
  assign dep_op = iss_cmov_dep &&
                  (iss_op == bac_pkg::BAC_OP_LOAD ||
                   iss_op == bac_pkg::BAC_OP_STORE ||
                   iss_op == bac_pkg::BAC_OP_PRELOAD ||
                   iss_op == bac_pkg::BAC_OP_IND_BRANCH);

  // ----------------------------------------------------------------
  // Issue hold
  // ----------------------------------------------------------------
  always_comb begin
    iss_stall = trk_if.full && is_access(iss_op);
    case (state)
      bac_pkg::BAC_ST_IDLE: begin
        iss_stall = iss_stall | ctx_sync_evt;
      end
      bac_pkg::BAC_ST_DSB_WAIT: begin
        iss_stall = 1'b1;
      end
      bac_pkg::BAC_ST_SPECULATION_DATA_BARRIER_WAIT: begin
        iss_stall = iss_stall | dep_op |
                    (iss_op >= bac_pkg::BAC_OP_DATA_SYNC);
      end
      bac_pkg::BAC_ST_SSB_WAIT: begin
        iss_stall = iss_stall | (iss_op == bac_pkg::BAC_OP_LOAD) |
                    (iss_op >= bac_pkg::BAC_OP_DATA_SYNC);
      end
      bac_pkg::BAC_ST_ISB_WAIT: begin
        iss_stall = 1'b1;
      end
      default: begin
        iss_stall = 1'b1;
      end
    endcase
  end

  assign accept = iss_valid && !iss_stall;

  // Group A is whatever is still counted when the barrier is taken
  always_comb begin
    dsb_met = scs_idle;
    if (need_rd && !rd_idle) begin
      dsb_met = 1'b0;
    end
    if (need_wr && !wr_idle) begin
      dsb_met = 1'b0;
    end
    if (need_maint && !maint_idle) begin
      dsb_met = 1'b0;
    end
  end

  assign ssb_met = phys_sb ? !st_phys_unknown : !st_addr_unknown;

  // ----------------------------------------------------------------
  // Tracker counts
  // ----------------------------------------------------------------
  always_comb begin
    trk_if.inc = '0;
    if (accept && is_access(iss_op)) begin
      trk_if.inc[class_of(iss_op)] = 1'b1;
    end
    trk_if.dec = {mem_scs_done, mem_maint_done, mem_wr_done, mem_rd_done};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_need_rd = need_rd;
    next_need_wr = need_wr;
    next_need_maint = need_maint;
    next_spec_pend = spec_pend;
    next_phys_sb = phys_sb;
    next_barrier_done = 1'b0;
    next_undef_op = 1'b0;
    next_scs_visible = 1'b0;
    next_mem_req_valid = 1'b0;
    next_mem_req_class = mem_req_class;
    next_mem_req_attr = mem_req_attr;
    case (state)
      bac_pkg::BAC_ST_IDLE: begin
        if (ctx_sync_evt) begin
          next_state = bac_pkg::BAC_ST_ISB_WAIT;
        end
      end
      bac_pkg::BAC_ST_DSB_WAIT: begin
        if (dsb_met) begin
          next_state = bac_pkg::BAC_ST_IDLE;
          next_barrier_done = 1'b1;
        end
      end
      bac_pkg::BAC_ST_SPECULATION_DATA_BARRIER_WAIT: begin
        if (spec_flush && spec_pend) begin
          next_state = bac_pkg::BAC_ST_IDLE;
          next_spec_pend = 1'b0;
        end else if (spec_pend) begin
          next_spec_pend = !spec_resolved;
        end else if (!older_spec_loads) begin
          next_state = bac_pkg::BAC_ST_IDLE;
          next_barrier_done = 1'b1;
        end
      end
      bac_pkg::BAC_ST_SSB_WAIT: begin
        if (ssb_met) begin
          next_state = bac_pkg::BAC_ST_IDLE;
          next_barrier_done = 1'b1;
        end
      end
      bac_pkg::BAC_ST_ISB_WAIT: begin
        if (scs_idle) begin
          next_state = bac_pkg::BAC_ST_IDLE;
          next_scs_visible = 1'b1;
          next_barrier_done = 1'b1;
        end
      end
      default: begin
        next_state = bac_pkg::BAC_ST_IDLE;
      end
    endcase

    if (accept) begin
      case (iss_op)
        bac_pkg::BAC_OP_LOAD,
        bac_pkg::BAC_OP_PRELOAD,
        bac_pkg::BAC_OP_STORE,
        bac_pkg::BAC_OP_MAINT,
        bac_pkg::BAC_OP_SCS_WRITE: begin
          next_mem_req_valid = 1'b1;
          next_mem_req_attr = attr_of(iss_normal, iss_cacheable,
                                      iss_shareable);
          next_mem_req_class = class_of(iss_op);
        end
        bac_pkg::BAC_OP_DATA_SYNC: begin
          next_state = bac_pkg::BAC_ST_DSB_WAIT;
          next_need_rd = iss_dsb_reads;
          next_need_wr = iss_dsb_writes;
          next_need_maint = iss_dsb_reads & iss_dsb_writes;
        end
        bac_pkg::BAC_OP_SPEC_DATA: begin
          if (FULL_PROFILE) begin
            next_state = bac_pkg::BAC_ST_SPECULATION_DATA_BARRIER_WAIT;
            next_spec_pend = iss_speculative;
          end else begin
            next_undef_op = 1'b1;
          end
        end
        bac_pkg::BAC_OP_PHYS_SB,
        bac_pkg::BAC_OP_SB: begin
          if (FULL_PROFILE) begin
            next_state = bac_pkg::BAC_ST_SSB_WAIT;
            next_phys_sb = (iss_op == bac_pkg::BAC_OP_PHYS_SB);
          end else begin
            next_undef_op = 1'b1;
          end
        end
        bac_pkg::BAC_OP_INSTR_SYNC: begin
          next_state = bac_pkg::BAC_ST_ISB_WAIT;
        end
        default: begin
          next_mem_req_valid = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write progress watch
  // ----------------------------------------------------------------
  always_comb begin
    next_wr_age = 16'h0000;
    next_wr_stuck = wr_stuck;
    if (wr_idle) begin
      next_wr_stuck = 1'b0;
    end else if (!mem_wr_done) begin
      next_wr_age = wr_age + 16'h0001;
      if (wr_age == 16'(WR_TIMEOUT_CYC - 1)) begin
        next_wr_stuck = 1'b1;
        next_wr_age = wr_age;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= bac_pkg::BAC_ST_IDLE;
      need_rd <= 1'b0;
      need_wr <= 1'b0;
      need_maint <= 1'b0;
      spec_pend <= 1'b0;
      phys_sb <= 1'b0;
      barrier_done <= 1'b0;
      undef_op <= 1'b0;
      scs_visible <= 1'b0;
      mem_req_valid <= 1'b0;
      mem_req_class <= bac_pkg::BAC_CL_READ;
      mem_req_attr <= 4'h0;
      wr_age <= 16'h0000;
      wr_stuck <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      need_rd <= next_need_rd;
      need_wr <= next_need_wr;
      need_maint <= next_need_maint;
      spec_pend <= next_spec_pend;
      phys_sb <= next_phys_sb;
      barrier_done <= next_barrier_done;
      undef_op <= next_undef_op;
      scs_visible <= next_scs_visible;
      mem_req_valid <= next_mem_req_valid;
      mem_req_class <= next_mem_req_class;
      mem_req_attr <= next_mem_req_attr;
      wr_age <= next_wr_age;
      wr_stuck <= next_wr_stuck;
    end
  end

  // Cache allocation and store forwarding guards
  assign alloc_inhibit = (state == bac_pkg::BAC_ST_SPECULATION_DATA_BARRIER_WAIT);
  assign bypass_inhibit = (state == bac_pkg::BAC_ST_SSB_WAIT);

endmodule : bac_barrier_ctrl
`default_nettype wire

// [verif/bac_mem_model.sv]
// Memory system model returning completions after a set delay
`timescale 1ns/1ps
`default_nettype none
module bac_mem_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Requests from the block
  input wire logic mem_req_valid,
  input wire bac_pkg::bac_class_t mem_req_class,
  input wire logic [3:0] dly,
  // Completions
  output logic mem_rd_done,
  output logic mem_wr_done,
  output logic mem_maint_done,
  output logic mem_scs_done
);
  // ----------------------------------------------------------------
  // Per-class countdown, zero delay never completes
  // ----------------------------------------------------------------
  logic [3:0] cnt [4];
  logic [3:0] hit;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit[i] = (cnt[i] == 4'h1);
    end
  end
  assign {mem_scs_done, mem_maint_done, mem_wr_done, mem_rd_done} = hit;
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        cnt[i] <= 4'h0;
      end else if (mem_req_valid && int'(mem_req_class) == i) begin
        cnt[i] <= dly;
      end else if (cnt[i] != 4'h0) begin
        cnt[i] <= cnt[i] - 4'h1;
      end
    end
  end
endmodule : bac_mem_model
`default_nettype wire

// [verif/bac_barrier_props.sv]
// Checker of barrier control port behaviour
`timescale 1ns/1ps
`default_nettype none
module bac_barrier_props #(
  parameter bit FULL_PROFILE = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Issue side
  input wire logic iss_valid,
  input wire bac_pkg::bac_op_t iss_op,
  input wire logic iss_speculative,
  input wire logic iss_cmov_dep,
  input wire logic iss_cacheable,
  input wire logic iss_stall,
  input wire logic barrier_done,
  input wire logic undef_op,
  // Speculation and bypass
  input wire logic spec_resolved,
  input wire logic older_spec_loads,
  input wire logic alloc_inhibit,
  input wire logic bypass_inhibit,
  input wire logic scs_visible,
  // Memory side
  input wire logic mem_req_valid,
  input wire bac_pkg::bac_class_t mem_req_class,
  input wire logic [3:0] mem_req_attr
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_take(bac_pkg::bac_op_t op);
    ce && iss_valid && !iss_stall && iss_op == op;
  endsequence
  property p_dsb_hold;
    s_take(bac_pkg::BAC_OP_DATA_SYNC) ##1 iss_valid |-> iss_stall;
  endproperty
  a_dsb_hold: assert property (p_dsb_hold)
    else $error("op taken during sync barrier");
  property p_dsb_gap;
    s_take(bac_pkg::BAC_OP_DATA_SYNC) |=> !barrier_done;
  endproperty
  a_dsb_gap: assert property (p_dsb_gap)
    else $error("sync barrier done too early");
  property p_speculation_data_barrier_spec;
    s_take(bac_pkg::BAC_OP_SPEC_DATA) ##0 iss_speculative
      ##1 !spec_resolved |=> !barrier_done;
  endproperty
  a_speculation_data_barrier_spec: assert property (p_speculation_data_barrier_spec)
    else $error("speculative barrier completed");
  property p_alloc_dep;
    alloc_inhibit && iss_valid && iss_cmov_dep && iss_op inside
      {bac_pkg::BAC_OP_LOAD, bac_pkg::BAC_OP_STORE,
       bac_pkg::BAC_OP_PRELOAD} |-> iss_stall;
  endproperty
  a_alloc_dep: assert property (p_alloc_dep)
    else $error("dependent access taken");
  property p_alloc_br;
    alloc_inhibit && iss_valid && iss_cmov_dep &&
      iss_op == bac_pkg::BAC_OP_IND_BRANCH |-> iss_stall;
  endproperty
  a_alloc_br: assert property (p_alloc_br)
    else $error("dependent branch taken");
  property p_spec_wait;
    alloc_inhibit && older_spec_loads |=> !barrier_done;
  endproperty
  a_spec_wait: assert property (p_spec_wait)
    else $error("done with speculative loads open");
  property p_bypass;
    bypass_inhibit && iss_valid && iss_op == bac_pkg::BAC_OP_LOAD
      |-> iss_stall;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("load taken during bypass barrier");
  property p_no_speculation_data_barrier;
    s_take(bac_pkg::BAC_OP_SPEC_DATA) |=> undef_op == !FULL_PROFILE;
  endproperty
  a_no_speculation_data_barrier: assert property (p_no_speculation_data_barrier)
    else $error("speculation barrier availability wrong");
  property p_no_ssb;
    (s_take(bac_pkg::BAC_OP_SB) or s_take(bac_pkg::BAC_OP_PHYS_SB))
      |=> undef_op == !FULL_PROFILE;
  endproperty
  a_no_ssb: assert property (p_no_ssb)
    else $error("bypass barrier availability wrong");
  property p_store_req;
    s_take(bac_pkg::BAC_OP_STORE) ##0 !iss_cacheable |=> mem_req_valid
      && mem_req_class == bac_pkg::BAC_CL_WRITE && mem_req_attr[3];
  endproperty
  a_store_req: assert property (p_store_req)
    else $error("store request wrong");
  property p_scs_vis;
    scs_visible |-> barrier_done;
  endproperty
  a_scs_vis: assert property (p_scs_vis)
    else $error("visibility without sync done");
endmodule : bac_barrier_props
bind bac_barrier_ctrl bac_barrier_props #(.FULL_PROFILE(FULL_PROFILE))
  i_props (.*);
`default_nettype wire

// [verif/testbench.sv]
// Testbench of the barrier and ordering control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, rst, ce, iss_valid, iss_dsb_reads, iss_dsb_writes;
  logic iss_speculative, iss_cmov_dep, iss_normal, iss_cacheable;
  logic iss_shareable, iss_stall, barrier_done, undef_op, spec_resolved;
  logic spec_flush, older_spec_loads, alloc_inhibit, st_addr_unknown;
  logic st_phys_unknown, bypass_inhibit, ctx_sync_evt, scs_visible;
  logic mem_req_valid, wr_stuck, mem_rd_done, mem_wr_done, lite_undef;
  logic mem_maint_done, mem_scs_done;
  logic [3:0] mem_req_attr, dly, seen;
  bac_pkg::bac_op_t iss_op;
  bac_pkg::bac_class_t mem_req_class;
  int bad_count, checks_done, undef_seen;
  // ----------------------------------------------------------------
  // Instances, clock and monitors
  // ----------------------------------------------------------------
  bac_barrier_ctrl #(.WR_TIMEOUT_CYC(8)) i_dut (.*);
  bac_barrier_ctrl #(.FULL_PROFILE(1'b0)) i_dut_lite (.*,
    .iss_stall(), .barrier_done(), .undef_op(lite_undef),
    .alloc_inhibit(), .bypass_inhibit(), .scs_visible(),
    .mem_req_valid(), .mem_req_class(), .mem_req_attr(), .wr_stuck());
  bac_mem_model i_mem (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    seen <= seen | {mem_scs_done, mem_maint_done, mem_wr_done, mem_rd_done};
    undef_seen <= undef_seen + int'(lite_undef);
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [3:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic issue(input bac_pkg::bac_op_t op);
    @(negedge core_clk);
    iss_op = op;
    iss_valid = 1'b1;
    for (int n = 0; n < 40; n++) begin
      #1;
      if (iss_stall !== 1'b1) break;
      @(negedge core_clk);
    end
    @(negedge core_clk);
    iss_valid = 1'b0;
  endtask : issue
  task automatic offer(input bac_pkg::bac_op_t op, input logic dep,
                       output logic st);
    @(negedge core_clk);
    iss_op = op;
    iss_cmov_dep = dep;
    iss_valid = 1'b1;
    #1;
    st = iss_stall;
    @(negedge core_clk);
    iss_valid = 1'b0;
    iss_cmov_dep = 1'b0;
  endtask : offer
  task automatic wait_done(input int lim);
    for (int n = 0; n < lim && barrier_done !== 1'b1; n++) begin
      @(negedge core_clk);
    end
  endtask : wait_done
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic dsb_case(input bac_pkg::bac_op_t op, input logic r, w,
                          input bac_pkg::bac_class_t cl);
    logic st;
    seen = 4'h0;
    issue(op);
    check("req", mem_req_valid, 1'b1);
    check("class", mem_req_class, cl);
    check("share", mem_req_attr[3], 1'b1);
    iss_dsb_reads = r;
    iss_dsb_writes = w;
    issue(bac_pkg::BAC_OP_DATA_SYNC);
    offer(bac_pkg::BAC_OP_LOAD, 1'b0, st);
    check("hold", st, 1'b1);
    wait_done(40);
    check("done", barrier_done, 1'b1);
    check("drained", seen[cl], 1'b1);
    check("release", iss_stall, 1'b0);
  endtask : dsb_case
  task automatic speculation_data_barrier_case();
    logic st;
    older_spec_loads = 1'b1;
    iss_speculative = 1'b1;
    issue(bac_pkg::BAC_OP_SPEC_DATA);
    check("inhibit", alloc_inhibit, 1'b1);
    offer(bac_pkg::BAC_OP_STORE, 1'b1, st);
    check("dep_st", st, 1'b1);
    offer(bac_pkg::BAC_OP_IND_BRANCH, 1'b1, st);
    check("dep_br", st, 1'b1);
    wait_done(4);
    check("early", barrier_done, 1'b0);
    spec_resolved = 1'b1;
    @(negedge core_clk);
    spec_resolved = 1'b0;
    wait_done(4);
    check("loads", barrier_done, 1'b0);
    older_spec_loads = 1'b0;
    wait_done(6);
    check("done", barrier_done, 1'b1);
    issue(bac_pkg::BAC_OP_SPEC_DATA);
    spec_flush = 1'b1;
    @(negedge core_clk);
    spec_flush = 1'b0;
    wait_done(6);
    check("abort", barrier_done, 1'b0);
    check("freed", alloc_inhibit, 1'b0);
    iss_speculative = 1'b0;
  endtask : speculation_data_barrier_case
  task automatic ssb_case(input bac_pkg::bac_op_t op, input logic phys);
    logic st;
    st_phys_unknown = phys;
    st_addr_unknown = !phys;
    issue(op);
    check("bypass", bypass_inhibit, 1'b1);
    offer(bac_pkg::BAC_OP_LOAD, 1'b0, st);
    check("ld_held", st, 1'b1);
    ce = 1'b0;
    st_phys_unknown = 1'b0;
    st_addr_unknown = 1'b0;
    repeat (2) @(negedge core_clk);
    check("frozen", bypass_inhibit, 1'b1);
    ce = 1'b1;
    wait_done(6);
    check("done", barrier_done, 1'b1);
  endtask : ssb_case
  task automatic sync_case(input logic ctx);
    seen = 4'h0;
    issue(bac_pkg::BAC_OP_SCS_WRITE);
    if (ctx) ctx_sync_evt = 1'b1;
    else issue(bac_pkg::BAC_OP_INSTR_SYNC);
    for (int n = 0; n < 20 && scs_visible !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    ctx_sync_evt = 1'b0;
    check("written", seen[3], 1'b1);
    check("visible", scs_visible, 1'b1);
  endtask : sync_case
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {rst, ce, iss_normal} = 3'h7;
    {iss_valid, iss_dsb_reads, iss_dsb_writes, iss_speculative} = 4'h0;
    {iss_cmov_dep, iss_cacheable, iss_shareable, spec_resolved} = 4'h0;
    {spec_flush, older_spec_loads, st_addr_unknown} = 3'h0;
    {st_phys_unknown, ctx_sync_evt} = 2'h0;
    iss_op = bac_pkg::BAC_OP_NONE;
    dly = 4'h4;
    seen = 4'h0;
    bad_count = 0;
    checks_done = 0;
    undef_seen = 0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    dsb_case(bac_pkg::BAC_OP_STORE, 1'b1, 1'b1, bac_pkg::BAC_CL_WRITE);
    dsb_case(bac_pkg::BAC_OP_LOAD, 1'b1, 1'b0, bac_pkg::BAC_CL_READ);
    dsb_case(bac_pkg::BAC_OP_MAINT, 1'b1, 1'b1, bac_pkg::BAC_CL_MAINT);
    dsb_case(bac_pkg::BAC_OP_SCS_WRITE, 1'b0, 1'b0, bac_pkg::BAC_CL_SCS);
    speculation_data_barrier_case();
    ssb_case(bac_pkg::BAC_OP_SB, 1'b0);
    ssb_case(bac_pkg::BAC_OP_PHYS_SB, 1'b1);
    sync_case(1'b0);
    sync_case(1'b1);
    check("lite", undef_seen[3:0], 4'h4);
    dly = 4'h0;
    iss_cacheable = 1'b1;
    issue(bac_pkg::BAC_OP_STORE);
    check("attr", mem_req_attr, 4'h7);
    repeat (10) @(negedge core_clk);
    check("stuck", wr_stuck, 1'b1);
    test_done();
  end
  initial begin
    #(25 * 2000);
    bad_count++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
